// *** hw/sfdd_pkg.sv ***
package sfdd_pkg;
   localparam logic [7:0] COUNTER_READBACK_MODE_STATE_OFFSET = 8'h10;
   localparam logic [7:0] BAUD_RELOAD_OFFSET = 8'h14;
   localparam logic [7:0] FIFO_DMA_OFFSET = 8'h18;

   localparam int COUNTER_READBACK_MODE_SHIFT_EN_BIT = 7;
   localparam int COUNTER_READBACK_MODE_TX_EN_BIT = 6;
   localparam int COUNTER_READBACK_MODE_STATE_LSB = 0;
   localparam int STATE_WIDTH = 6;

   localparam int BAUD_LSB = 0;
   localparam int BAUD_WIDTH = 16;
   localparam logic [15:0] BAUD_RESET = 16'hffff;

   localparam int RX_DMA_EN_BIT = 31;
   localparam int RX_COUNT_LSB = 24;
   localparam int RX_FLUSH_BIT = 20;
   localparam int RX_LEVEL_LSB = 16;
   localparam int TX_DMA_EN_BIT = 15;
   localparam int TX_COUNT_LSB = 8;
   localparam int TX_FLUSH_BIT = 4;
   localparam int TX_LEVEL_LSB = 0;
   localparam int COUNT_WIDTH = 3;
   localparam int LEVEL_WIDTH = 2;
   localparam logic [1:0] LEVEL_RESET = 2'h3;
   localparam logic DMA_EN_RESET = 1'b0;

   localparam int FIFO_DEPTH = 4;
   localparam logic [2:0] FIFO_FULL_COUNT = 3'h4;
endpackage : sfdd_pkg

// *** hw/sfdd_skid_buffer.sv ***
`timescale 1ns/1ps
// Two-entry buffer; the head entry always sits in a flip-flop.
module sfdd_skid_buffer #(
   parameter int WIDTH = 16
) (
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [WIDTH-1:0] in_data,
   output logic out_valid,
   input wire logic out_ready,
   output logic [WIDTH-1:0] out_data
);
   logic head_valid_reg;
   logic tail_valid_reg;
   logic [WIDTH-1:0] head_data_reg;
   logic [WIDTH-1:0] tail_data_reg;
   logic take;
   logic give;

   assign take = in_valid && !tail_valid_reg;
   assign give = head_valid_reg && out_ready;
   assign in_ready = !tail_valid_reg;
   assign out_valid = head_valid_reg;
   assign out_data = head_data_reg;

   always_ff @(posedge clk)
   begin
      if (sys_rst)
      begin
         head_valid_reg <= 1'b0;
         tail_valid_reg <= 1'b0;
      end
      else if (give)
      begin
         head_valid_reg <= tail_valid_reg || take;
         tail_valid_reg <= 1'b0;
      end
      else if (take)
      begin
         head_valid_reg <= 1'b1;
         tail_valid_reg <= head_valid_reg;
      end
   end

   always_ff @(posedge clk)
   begin
      if (give)
      begin
         head_data_reg <= tail_valid_reg ? tail_data_reg : in_data;
      end
      else if (take && !head_valid_reg)
      begin
         head_data_reg <= in_data;
      end
      if (take && head_valid_reg && !give)
      begin
         tail_data_reg <= in_data;
      end
   end
endmodule : sfdd_skid_buffer

// *** hw/sfdd_top.sv ***
`timescale 1ns/1ps
module sfdd_top #(
   parameter int DATA_WIDTH = 16
) (
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic [7:0] reg_addr,
   input wire logic [31:0] reg_wdata,
   input wire logic reg_write,
   input wire logic reg_read,
   output logic [31:0] reg_rdata,
   input wire logic shift_clock_enable,
   input wire logic transmit_clock_enable,
   input wire logic [5:0] serial_fsm_state,
   input wire logic [15:0] baud_counter,
   input wire logic counter_readback_mode,
   output logic [15:0] baud_reload_value,
   input wire logic rx_push,
   input wire logic [DATA_WIDTH-1:0] rx_push_data,
   output logic rx_fifo_full,
   output logic rx_out_valid,
   input wire logic rx_out_ready,
   output logic [DATA_WIDTH-1:0] rx_out_data,
   output logic rx_dma_req,
   input wire logic tx_in_valid,
   output logic tx_in_ready,
   input wire logic [DATA_WIDTH-1:0] tx_in_data,
   input wire logic tx_pop,
   output logic tx_pop_valid,
   output logic [DATA_WIDTH-1:0] tx_pop_data,
   output logic tx_dma_req
);
   logic [15:0] baud_reload_reg;
   logic rx_dma_enable_reg;
   logic tx_dma_enable_reg;
   logic [1:0] rx_level_reg;
   logic [1:0] tx_level_reg;
   logic rx_dma_enable_next;
   logic tx_dma_enable_next;
   logic [1:0] rx_level_next;
   logic [1:0] tx_level_next;
   logic [31:0] reg_rdata_reg;
   logic dma_write;
   logic receive_fifo_flush;
   logic transmit_fifo_flush;

   localparam int FIFO_DEPTH_L = sfdd_pkg::FIFO_DEPTH;
   logic [DATA_WIDTH-1:0] rx_mem [FIFO_DEPTH_L];
   logic [DATA_WIDTH-1:0] tx_mem [FIFO_DEPTH_L];
   // Pointers wrap by themselves at four entries; counts are one bit wider so that full differs from empty.
   logic [1:0] rx_wr_ptr_reg;
   logic [1:0] rx_rd_ptr_reg;
   logic [2:0] receive_fifo_count_reg;
   logic [2:0] rx_count_next;
   logic [1:0] tx_wr_ptr_reg;
   logic [1:0] tx_rd_ptr_reg;
   logic [2:0] transmit_fifo_count_reg;
   logic [2:0] tx_count_next;
   logic rx_do_push;
   logic rx_do_pop;
   logic buf_in_ready;
   logic tx_do_push;
   logic tx_do_pop;
   logic tx_in_ready_reg;
   logic rx_fifo_full_reg;
   logic rx_dma_req_reg;
   logic tx_dma_req_reg;
   logic tx_pop_valid_reg;
   logic [DATA_WIDTH-1:0] tx_pop_data_reg;

   // True when a count meets a level code; codes 0..3 mean 1..4 entries.
   function automatic logic level_met(input logic [2:0] entries, input logic [1:0] level);
      level_met = entries >= ({1'b0, level} + 3'h1);
   endfunction : level_met

   // Next occupancy of one FIFO; a flush empties it whatever else happens in that cycle.
   function automatic logic [2:0] next_count(input logic [2:0] count, input logic flush, input logic push,
                                              input logic pop);
      if (flush)
      begin
         next_count = 3'h0;
      end
      else if (push && !pop)
      begin
         next_count = count + 3'h1;
      end
      else if (pop && !push)
      begin
         next_count = count - 3'h1;
      end
      else
      begin
         next_count = count;
      end
   endfunction : next_count

   // Flush bits act only in the cycle of the write and are never stored, so they read as zero.
   assign dma_write = reg_write && (reg_addr == sfdd_pkg::FIFO_DMA_OFFSET);
   assign receive_fifo_flush = dma_write && reg_wdata[sfdd_pkg::RX_FLUSH_BIT];
   assign transmit_fifo_flush = dma_write && reg_wdata[sfdd_pkg::TX_FLUSH_BIT];

   assign rx_dma_enable_next = dma_write ? reg_wdata[sfdd_pkg::RX_DMA_EN_BIT] : rx_dma_enable_reg;
   assign tx_dma_enable_next = dma_write ? reg_wdata[sfdd_pkg::TX_DMA_EN_BIT] : tx_dma_enable_reg;
   assign rx_level_next = dma_write ? reg_wdata[sfdd_pkg::RX_LEVEL_LSB +: sfdd_pkg::LEVEL_WIDTH] : rx_level_reg;
   assign tx_level_next = dma_write ? reg_wdata[sfdd_pkg::TX_LEVEL_LSB +: sfdd_pkg::LEVEL_WIDTH] : tx_level_reg;

   // Only the low half of the baud word is stored; the upper half reads as zero.
   always_ff @(posedge clk)
   begin
      if (sys_rst)
      begin
         baud_reload_reg <= sfdd_pkg::BAUD_RESET;
      end
      else if (reg_write && reg_addr == sfdd_pkg::BAUD_RELOAD_OFFSET)
      begin
         baud_reload_reg <= reg_wdata[sfdd_pkg::BAUD_LSB +: sfdd_pkg::BAUD_WIDTH];
      end
   end

   always_ff @(posedge clk)
   begin
      if (sys_rst)
      begin
         rx_dma_enable_reg <= sfdd_pkg::DMA_EN_RESET;
         tx_dma_enable_reg <= sfdd_pkg::DMA_EN_RESET;
         rx_level_reg <= sfdd_pkg::LEVEL_RESET;
         tx_level_reg <= sfdd_pkg::LEVEL_RESET;
      end
      else
      begin
         // Enables and levels follow a write to the control word at its edge.
         rx_dma_enable_reg <= rx_dma_enable_next;
         tx_dma_enable_reg <= tx_dma_enable_next;
         rx_level_reg <= rx_level_next;
         tx_level_reg <= tx_level_next;
      end
   end

   // Receive FIFO: a push into a full FIFO is dropped; flush beats push and pop.
   assign rx_do_push = rx_push && (receive_fifo_count_reg != sfdd_pkg::FIFO_FULL_COUNT);
   assign rx_do_pop = buf_in_ready && (receive_fifo_count_reg != 3'h0);
   assign rx_count_next = next_count(receive_fifo_count_reg, receive_fifo_flush, rx_do_push, rx_do_pop);

   always_ff @(posedge clk)
   begin
      if (sys_rst)
      begin
         rx_wr_ptr_reg <= 2'h0;
         rx_rd_ptr_reg <= 2'h0;
         receive_fifo_count_reg <= 3'h0;
      end
      else
      begin
         receive_fifo_count_reg <= rx_count_next;
         if (receive_fifo_flush)
         begin
            rx_wr_ptr_reg <= 2'h0;
            rx_rd_ptr_reg <= 2'h0;
         end
         else
         begin
            if (rx_do_push)
            begin
               rx_wr_ptr_reg <= rx_wr_ptr_reg + 2'h1;
            end
            if (rx_do_pop)
            begin
               rx_rd_ptr_reg <= rx_rd_ptr_reg + 2'h1;
            end
         end
      end
   end

   always_ff @(posedge clk)
   begin
      // A word pushed in the cycle of a flush is dropped with the rest.
      if (rx_do_push && !receive_fifo_flush)
      begin
         rx_mem[rx_wr_ptr_reg] <= rx_push_data;
      end
   end

   // The buffer lets the DMA side stall without losing a word already taken from the FIFO.
   sfdd_skid_buffer #(
      .WIDTH(DATA_WIDTH)
   ) u_rx_buffer (
      .clk(clk),
      .sys_rst(sys_rst),
      .in_valid(rx_do_pop && !receive_fifo_flush),
      .in_ready(buf_in_ready),
      .in_data(rx_mem[rx_rd_ptr_reg]),
      .out_valid(rx_out_valid),
      .out_ready(rx_out_ready),
      .out_data(rx_out_data)
   );

   // Transmit FIFO: filled by the DMA side, drained by the shift engine.
   assign tx_do_push = tx_in_valid && tx_in_ready_reg;
   assign tx_do_pop = tx_pop && (transmit_fifo_count_reg != 3'h0);
   assign tx_count_next = next_count(transmit_fifo_count_reg, transmit_fifo_flush, tx_do_push, tx_do_pop);

   always_ff @(posedge clk)
   begin
      if (sys_rst)
      begin
         tx_wr_ptr_reg <= 2'h0;
         tx_rd_ptr_reg <= 2'h0;
         transmit_fifo_count_reg <= 3'h0;
         tx_in_ready_reg <= 1'b1;
      end
      else
      begin
         transmit_fifo_count_reg <= tx_count_next;
         // Ready follows the next count, so it drops at the edge that fills the last entry.
         tx_in_ready_reg <= (tx_count_next != sfdd_pkg::FIFO_FULL_COUNT);
         if (transmit_fifo_flush)
         begin
            tx_wr_ptr_reg <= 2'h0;
            tx_rd_ptr_reg <= 2'h0;
         end
         else
         begin
            if (tx_do_push)
            begin
               tx_wr_ptr_reg <= tx_wr_ptr_reg + 2'h1;
            end
            if (tx_do_pop)
            begin
               tx_rd_ptr_reg <= tx_rd_ptr_reg + 2'h1;
            end
         end
      end
   end

   always_ff @(posedge clk)
   begin
      // A word pushed in the cycle of a flush is dropped with the rest.
      if (tx_do_push && !transmit_fifo_flush)
      begin
         tx_mem[tx_wr_ptr_reg] <= tx_in_data;
      end
   end

   // A pop outside a flush cycle returns its word in the following cycle with a one-cycle valid.
   always_ff @(posedge clk)
   begin
      if (sys_rst)
      begin
         tx_pop_valid_reg <= 1'b0;
         tx_pop_data_reg <= '0;
      end
      else
      begin
         tx_pop_valid_reg <= tx_do_pop && !transmit_fifo_flush;
         if (tx_do_pop)
         begin
            tx_pop_data_reg <= tx_mem[tx_rd_ptr_reg];
         end
      end
   end

   // Requests are computed from next-cycle state so they track flushes and enables at once.
   always_ff @(posedge clk)
   begin
      if (sys_rst)
      begin
         rx_dma_req_reg <= 1'b0;
         tx_dma_req_reg <= 1'b0;
         rx_fifo_full_reg <= 1'b0;
      end
      else
      begin
         rx_dma_req_reg <= rx_dma_enable_next && level_met(rx_count_next, rx_level_next);
         tx_dma_req_reg <= tx_dma_enable_next
                           && level_met(sfdd_pkg::FIFO_FULL_COUNT - tx_count_next, tx_level_next);
         rx_fifo_full_reg <= (rx_count_next == sfdd_pkg::FIFO_FULL_COUNT);
      end
   end

   always_ff @(posedge clk)
   begin
      if (sys_rst)
      begin
         reg_rdata_reg <= 32'h0;
      end
      else if (reg_read)
      begin
         reg_rdata_reg <= 32'h0;
         // Unmapped addresses and all reserved bits read as zero.
         unique case (reg_addr)
            sfdd_pkg::COUNTER_READBACK_MODE_STATE_OFFSET:
            begin
               reg_rdata_reg[sfdd_pkg::COUNTER_READBACK_MODE_SHIFT_EN_BIT] <= shift_clock_enable;
               reg_rdata_reg[sfdd_pkg::COUNTER_READBACK_MODE_TX_EN_BIT] <= transmit_clock_enable;
               reg_rdata_reg[sfdd_pkg::COUNTER_READBACK_MODE_STATE_LSB +: sfdd_pkg::STATE_WIDTH] <= serial_fsm_state;
            end
            sfdd_pkg::BAUD_RELOAD_OFFSET:
            begin
               reg_rdata_reg[sfdd_pkg::BAUD_LSB +: sfdd_pkg::BAUD_WIDTH] <=
                  counter_readback_mode ? baud_counter : baud_reload_reg;
            end
            sfdd_pkg::FIFO_DMA_OFFSET:
            begin
               reg_rdata_reg[sfdd_pkg::RX_DMA_EN_BIT] <= rx_dma_enable_reg;
               reg_rdata_reg[sfdd_pkg::RX_COUNT_LSB +: sfdd_pkg::COUNT_WIDTH] <= receive_fifo_count_reg;
               reg_rdata_reg[sfdd_pkg::RX_LEVEL_LSB +: sfdd_pkg::LEVEL_WIDTH] <= rx_level_reg;
               reg_rdata_reg[sfdd_pkg::TX_DMA_EN_BIT] <= tx_dma_enable_reg;
               reg_rdata_reg[sfdd_pkg::TX_COUNT_LSB +: sfdd_pkg::COUNT_WIDTH] <= transmit_fifo_count_reg;
               reg_rdata_reg[sfdd_pkg::TX_LEVEL_LSB +: sfdd_pkg::LEVEL_WIDTH] <= tx_level_reg;
            end
            default:
            begin
               reg_rdata_reg <= 32'h0;
            end
         endcase
      end
   end

   // Every output is driven straight from a register.
   assign reg_rdata = reg_rdata_reg;
   assign baud_reload_value = baud_reload_reg;
   assign rx_fifo_full = rx_fifo_full_reg;
   assign rx_dma_req = rx_dma_req_reg;
   assign tx_dma_req = tx_dma_req_reg;
   assign tx_in_ready = tx_in_ready_reg;
   assign tx_pop_valid = tx_pop_valid_reg;
   assign tx_pop_data = tx_pop_data_reg;
endmodule : sfdd_top

// *** verif/sfdd_properties.sv ***
`timescale 1ns/1ps
module sfdd_properties (
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic [7:0] reg_addr,
   input wire logic [31:0] reg_wdata,
   input wire logic reg_write,
   input wire logic reg_read,
   input wire logic [31:0] reg_rdata,
   input wire logic shift_clock_enable,
   input wire logic transmit_clock_enable,
   input wire logic [5:0] serial_fsm_state,
   input wire logic [15:0] baud_counter,
   input wire logic counter_readback_mode,
   input wire logic [15:0] baud_reload_value,
   input wire logic rx_fifo_full,
   input wire logic rx_dma_req,
   input wire logic tx_in_ready,
   input wire logic tx_dma_req
);
   logic rx_en_q;
   logic tx_en_q;
   default clocking cb @(posedge clk); endclocking
   default disable iff (sys_rst);
   // Shadow copies of the two enables, updated at the same edge as the design.
   always_ff @(posedge clk)
   begin
      if (sys_rst)
      begin
         rx_en_q <= 1'b0;
         tx_en_q <= 1'b0;
      end
      else if (reg_write && reg_addr == 8'h18)
      begin
         rx_en_q <= reg_wdata[31];
         tx_en_q <= reg_wdata[15];
      end
   end
   baud_reset_a: assert property ($fell(sys_rst) |-> baud_reload_value == 16'hffff)
      else $error("baud reload not ffff after reset");
   rx_gate_a: assert property (!rx_en_q |-> !rx_dma_req)
      else $error("rx request while disabled");
   tx_gate_a: assert property (!tx_en_q |-> !tx_dma_req)
      else $error("tx request while disabled");
   counter_readback_mode_read_a: assert property (reg_read && reg_addr == 8'h10 |=> reg_rdata == {24'h0,
      $past(shift_clock_enable), $past(transmit_clock_enable), $past(serial_fsm_state)})
      else $error("diagnostic read mismatch");
   baud_read_a: assert property (reg_read && reg_addr == 8'h14 && !counter_readback_mode
      |=> reg_rdata == {16'h0, $past(baud_reload_value)})
      else $error("baud read mismatch");
   live_count_a: assert property (reg_read && reg_addr == 8'h14 && counter_readback_mode
      |=> reg_rdata == {16'h0, $past(baud_counter)})
      else $error("live counter read mismatch");
   rx_full_req_a: assert property (rx_fifo_full && rx_en_q |-> rx_dma_req)
      else $error("full rx fifo without request");
   tx_free_req_a: assert property (tx_dma_req |-> tx_in_ready)
      else $error("tx request with no free entry");
endmodule : sfdd_properties
bind sfdd_top sfdd_properties chk_u (.clk, .sys_rst, .reg_addr, .reg_wdata, .reg_write, .reg_read, .reg_rdata,
   .shift_clock_enable, .transmit_clock_enable, .serial_fsm_state, .baud_counter, .counter_readback_mode,
   .baud_reload_value, .rx_fifo_full, .rx_dma_req, .tx_in_ready, .tx_dma_req);

// *** verif/sfdd_dma_model.sv ***
`timescale 1ns/1ps
module sfdd_dma_model (
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic stall,
   input wire logic [3:0] quota,
   input wire logic rx_out_valid,
   input wire logic [15:0] rx_out_data,
   output logic rx_out_ready,
   output logic tx_in_valid,
   input wire logic tx_in_ready,
   output logic [15:0] tx_in_data
);
   logic [3:0] sent;
   logic [15:0] got [0:7];
   logic [2:0] n_got;
   logic acc;
   assign acc = tx_in_valid & tx_in_ready;
   // Data lines carry the inverse of the next word number while no word is offered.
   assign tx_in_data = tx_in_valid ? {12'h0, sent} + 16'h1 : ~({12'h0, sent} + 16'h1);
   // Offers words numbered from one, holding each until taken, up to quota words.
   always @(posedge clk)
   begin
      if (sys_rst)
      begin
         sent <= 4'h0;
         tx_in_valid <= 1'b0;
         rx_out_ready <= 1'b0;
         n_got <= 3'h0;
      end
      else
      begin
         sent <= sent + {3'h0, acc};
         tx_in_valid <= (sent + {3'h0, acc}) < quota;
         rx_out_ready <= !stall;
         if (rx_out_valid && rx_out_ready)
         begin
            got[n_got] <= rx_out_data;
            n_got <= n_got + 3'h1;
         end
      end
   end
endmodule : sfdd_dma_model

// *** verif/spi_fifo_dma_counter_readback_mode_regs_tb.sv ***
`timescale 1ns/1ps
module spi_fifo_dma_counter_readback_mode_regs_tb;
   logic clk = 0, sys_rst = 1, reg_write = 0, reg_read = 0, sce = 0, tce = 0, mode = 0, rx_push = 0, tx_pop = 0;
   logic stall = 1;
   logic [7:0] reg_addr = 8'h0;
   logic [31:0] reg_wdata = 32'h0, reg_rdata;
   logic [5:0] st = 6'h0;
   logic [15:0] bcnt = 16'h0, brv, rx_push_data = 16'h0, rx_out_data, tx_in_data, tx_pop_data;
   logic [3:0] quota = 4'h0;
   logic rx_fifo_full, rx_out_valid, rx_out_ready, rx_dma_req, tx_in_valid, tx_in_ready, tx_pop_valid, tx_dma_req;
   int err_count = 0, n_compared = 0;
   always #12.5 clk = ~clk;
   sfdd_top dut_u (.clk, .sys_rst, .reg_addr, .reg_wdata, .reg_write, .reg_read, .reg_rdata,
      .shift_clock_enable(sce), .transmit_clock_enable(tce), .serial_fsm_state(st), .baud_counter(bcnt),
      .counter_readback_mode(mode), .baud_reload_value(brv), .rx_push, .rx_push_data, .rx_fifo_full,
      .rx_out_valid, .rx_out_ready, .rx_out_data, .rx_dma_req, .tx_in_valid, .tx_in_ready, .tx_in_data,
      .tx_pop, .tx_pop_valid, .tx_pop_data, .tx_dma_req);
   sfdd_dma_model dma_u (.clk, .sys_rst, .stall, .quota, .rx_out_valid, .rx_out_data, .rx_out_ready,
      .tx_in_valid, .tx_in_ready, .tx_in_data);
   task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
      n_compared++;
      if (seen !== exp)
      begin
         err_count++;
         $display("[ERR] %s expected %h seen %h", what, exp, seen);
      end
   endtask : chk
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk) {reg_write, reg_addr, reg_wdata} <= {1'b1, a, d};
      @(posedge clk) reg_write <= 1'b0;
      #1;
   endtask : wr
   task automatic rd(input logic [7:0] a, input logic [31:0] exp);
      @(posedge clk) {reg_read, reg_addr} <= {1'b1, a};
      @(posedge clk) reg_read <= 1'b0;
      #1 chk("rdata", reg_rdata, exp);
   endtask : rd
   task automatic final_report;
      $display("compared %0d mismatches %0d", n_compared, err_count);
      if (err_count == 0 && n_compared > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask : final_report
   initial
   begin
      repeat (3000) @(posedge clk);
      err_count++;
      final_report;
   end
   initial
   begin
      repeat (16) @(posedge clk);
      sys_rst <= 1'b0;
      rd(8'h14, 32'h0000ffff);
      rd(8'h18, 32'h00030003);
      @(posedge clk) {sce, tce, st} <= {2'b10, 6'h2a};
      rd(8'h10, 32'h000000aa);
      @(posedge clk) {sce, tce, st} <= {2'b01, 6'h15};
      rd(8'h10, 32'h00000055);
      wr(8'h14, 32'h1234a5a5);
      chk("reload", brv, 32'ha5a5);
      rd(8'h14, 32'h0000a5a5);
      @(posedge clk) {mode, bcnt} <= {1'b1, 16'h5a5a};
      rd(8'h14, 32'h00005a5a);
      @(posedge clk) mode <= 1'b0;
      wr(8'h1c, 32'hffffffff);
      rd(8'h1c, 32'h0);
      wr(8'h18, 32'h00008000);
      chk("txreq", tx_dma_req, 1);
      @(posedge clk) quota <= 4'h4;
      repeat (8) @(posedge clk);
      #1 chk("txrdy", tx_in_ready, 0);
      rd(8'h18, 32'h00008400);
      for (int c = 4; c >= 0; c--)
      begin
         for (int lv = 0; lv < 4; lv++)
         begin
            wr(8'h18, 32'h00008000 | lv);
            chk("txreq", tx_dma_req, (4 - c) >= lv + 1);
         end
         if (c > 0)
         begin
            @(posedge clk) tx_pop <= 1'b1;
            @(posedge clk) tx_pop <= 1'b0;
            #1 chk("popdata", {tx_pop_valid, tx_pop_data}, 17'h10000 + 5 - c);
         end
      end
      @(posedge clk) quota <= 4'h6;
      repeat (6) @(posedge clk);
      wr(8'h18, 32'h00008013);
      chk("txreq", tx_dma_req, 1);
      rd(8'h18, 32'h00008003);
      wr(8'h18, 32'h00000003);
      chk("txreq", tx_dma_req, 0);
      for (int i = 0; i < 7; i++)
         @(posedge clk) {rx_push, rx_push_data} <= {1'b1, 16'h10 + i[15:0]};
      @(posedge clk) rx_push <= 1'b0;
      repeat (4) @(posedge clk);
      wr(8'h18, 32'h80030000);
      chk("rxreq", {rx_dma_req, rx_fifo_full}, 2'b11);
      rd(8'h18, 32'h84030000);
      wr(8'h18, 32'h80130000);
      chk("rxreq", rx_dma_req, 0);
      rd(8'h18, 32'h80030000);
      @(posedge clk) {rx_push, rx_push_data} <= {1'b1, 16'h20};
      @(posedge clk) rx_push <= 1'b0;
      repeat (3) @(posedge clk);
      for (int lv = 0; lv < 4; lv++)
      begin
         wr(8'h18, 32'h80000000 | (lv << 16));
         chk("rxreq", rx_dma_req, lv == 0);
      end
      wr(8'h18, 32'h0);
      chk("rxreq", rx_dma_req, 0);
      @(posedge clk) stall <= 1'b0;
      repeat (8) @(posedge clk);
      #1 chk("rxcount", dma_u.n_got, 3);
      chk("rxword0", dma_u.got[0], 32'h10);
      chk("rxword1", dma_u.got[1], 32'h11);
      chk("rxword2", dma_u.got[2], 32'h20);
      final_report;
   end
endmodule : spi_fifo_dma_counter_readback_mode_regs_tb
